// File: design/srfb_pkg.sv
// shared constants and types for the response frame builder
package srfb_pkg;
  // frame layout, byte positions and lengths inside the response unit
  localparam logic [10:0] OFS_QUAL      = 11'h008;
  localparam logic [10:0] OFS_FMT       = 11'h00a;
  localparam logic [10:0] OFS_STATUS    = 11'h00b;
  localparam logic [10:0] OFS_SENSE_LEN = 11'h010;
  localparam logic [10:0] OFS_REPLY_LEN = 11'h014;
  localparam logic [10:0] OFS_PAYLOAD   = 11'h018;
  localparam logic [10:0] REPLY_LEN     = 11'h004;
  localparam logic [15:0] SENSE_MAX     = 16'h03e8;
  // payload format codes
  localparam logic [1:0] FMT_NONE  = 2'h0;
  localparam logic [1:0] FMT_REPLY = 2'h1;
  localparam logic [1:0] FMT_SENSE = 2'h2;
  localparam logic [1:0] FMT_RSVD  = 2'h3;
  // reply codes
  localparam logic [7:0] RC_COMPLETE    = 8'h00;
  localparam logic [7:0] RC_INVALID     = 8'h02;
  localparam logic [7:0] RC_NOT_SUPP    = 8'h04;
  localparam logic [7:0] RC_FAILED      = 8'h05;
  localparam logic [7:0] RC_SUCCEEDED   = 8'h08;
  localparam logic [7:0] RC_BAD_LUN     = 8'h09;
  localparam logic [7:0] RC_OVERLAP_TAG = 8'h0a;
  // register map
  localparam logic [7:0]  REG_TMF_SUPPORT = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_SENSE_ADDR  = 8'h08;
  localparam logic [7:0]  REG_SENSE_DATA  = 8'h0c;
  localparam logic [7:0]  REG_FRAME_CNT   = 8'h10;
  localparam logic [31:0] TMF_SUPPORT_RST = 32'hffffffff;
  // sizes
  localparam int TAG_SLOTS   = 8;
  localparam int SENSE_WORDS = 250;

  typedef enum logic [2:0] {
    REQ_OPEN_CMD,
    REQ_OPEN_TMF,
    REQ_CMD_DONE,
    REQ_TMF_DONE,
    REQ_XPORT_ERR
  } srfb_kind_t;

  typedef struct packed {
    srfb_kind_t  kind;
    logic [15:0] tag;
    logic [7:0]  status;
    logic [15:0] qualifier;
    logic [15:0] sense_len;
    logic [7:0]  tmf_func;
    logic [7:0]  reply_code;
    logic [23:0] extra_info;
  } srfb_req_t;

  typedef struct packed {
    logic [7:0]  data;
    logic        last;
    logic [1:0]  fill;
    logic [15:0] tag;
  } srfb_tx_t;
endpackage : srfb_pkg

// File: design/srfb_tag_slot.sv
// one entry of the outstanding tag table
`timescale 1ns/100ps
module srfb_tag_slot (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // control
  input  wire logic        alloc_in,
  input  wire logic        free_in,
  input  wire logic [15:0] tag_in,
  // state
  output logic             busy_out,
  output logic             hit_out
);
  logic [15:0] tag_q;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
    end else if (alloc_in) begin
      busy_out <= 1'b1;
    end else if (free_in) begin
      busy_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tag_q <= 16'h0000;
    end else if (alloc_in) begin
      tag_q <= tag_in;
    end
  end

  assign hit_out = busy_out && (tag_q == tag_in);
endmodule : srfb_tag_slot

// File: design/srfb_sense_ram.sv
// sense payload store, one write port and two read ports
`timescale 1ns/100ps
module srfb_sense_ram (
  // clock
  input  wire logic        mclk_in,
  // write port
  input  wire logic        we_in,
  input  wire logic [7:0]  waddr_in,
  input  wire logic [31:0] wdata_in,
  // read ports
  input  wire logic [7:0]  raddr_a_in,
  output logic      [31:0] rdata_a_out,
  input  wire logic [7:0]  raddr_b_in,
  output logic      [31:0] rdata_b_out
);
  logic [31:0] mem [srfb_pkg::SENSE_WORDS];

  // no reset: contents are only meaningful once software loads them
  always_ff @(posedge mclk_in) begin
    if (we_in && (waddr_in < 8'(srfb_pkg::SENSE_WORDS))) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  assign rdata_a_out = (raddr_a_in < 8'(srfb_pkg::SENSE_WORDS)) ? mem[raddr_a_in] : 32'h00000000;
  assign rdata_b_out = (raddr_b_in < 8'(srfb_pkg::SENSE_WORDS)) ? mem[raddr_b_in] : 32'h00000000;
endmodule : srfb_sense_ram

// File: design/srfb_builder.sv
// response unit builder: request decode, tag tracking, byte serialiser, registers
// Function
// - sense length, four bytes big-endian, at bytes 16..19 after reserved 12..15
// - reply length at 20..23; reply at 24; sense at 24 plus reply length
// - format code: 00 none, 01 protocol reply, 10 sense, 11 reserved
// - command ending without sense data uses the no-payload format
// - every task-management answer and transport error uses the reply format
// - command ending with sense data uses the sense format
// - no-payload: status and qualifier filled, both lengths zero, no payloads
// - reply format: status and sense length zero, reply length four, reply present
// - reply payload is four bytes, reply code in its last byte
// - reply payload present for non-zero codes and every task-management answer
// - extra reply information is zero when undefined or unsupported
// - reply codes 00,02,04,05,08,09,0a; other values reserved
// - reused outstanding tag answers with overlapped-tag code
// - sense format: status, qualifier, reply length zero, sense length 1..1000
// - sense length not multiple of four gives non-zero fill count and pads
// - interleaved frames of different sequences are accepted
// - responses may leave in any order relative to the requests
// - sequences may span several connections or share one
// - unit never exceeds the largest information unit allowed
// - reserved or unsupported task function answers with not-supported code
`timescale 1ns/100ps
module srfb_builder (
  // clock and reset
  input  wire logic               mclk_in,
  input  wire logic               rst_n_in,
  // request port
  input  wire logic               req_valid_in,
  input  wire srfb_pkg::srfb_req_t req_in,
  output logic                    req_ready_out,
  // byte stream to the framing logic
  output logic                    tx_valid_out,
  output srfb_pkg::srfb_tx_t      tx_out,
  input  wire logic               tx_ready_in,
  // register port
  input  wire logic [7:0]         addr_in,
  input  wire logic [31:0]        wr_data_in,
  input  wire logic               wr_in,
  input  wire logic               rd_in,
  output logic      [31:0]        rd_data_out
);
  typedef enum logic {S_IDLE, S_EMIT} srfb_state_t;

  srfb_state_t state_q;
  srfb_state_t state_d;

  // frame fields held for the whole emission
  logic [1:0]  fmt_q;
  logic [7:0]  status_q;
  logic [15:0] qual_q;
  logic [15:0] sense_len_q;
  logic [10:0] reply_len_q;
  logic [7:0]  code_q;
  logic [23:0] extra_q;
  logic [15:0] tag_q;
  logic [1:0]  fill_q;
  logic [10:0] total_q;
  logic [10:0] idx_q;

  // registers
  logic [31:0] tmf_sup_q;
  logic [7:0]  sense_addr_q;
  logic [15:0] frame_cnt_q;

  // decoded request
  logic        take;
  logic        go;
  logic        alloc_ok;
  logic        release_tag;
  logic [1:0]  fmt_d;
  logic [7:0]  status_d;
  logic [15:0] qual_d;
  logic [15:0] sense_len_d;
  logic [10:0] reply_len_d;
  logic [7:0]  code_d;
  logic [23:0] extra_d;
  logic [1:0]  fill_d;
  logic        tmf_unsupported;

  // tag table
  logic [srfb_pkg::TAG_SLOTS-1:0] slot_busy;
  logic [srfb_pkg::TAG_SLOTS-1:0] slot_hit;
  logic [srfb_pkg::TAG_SLOTS-1:0] alloc_oh;
  logic [srfb_pkg::TAG_SLOTS-1:0] free_v;
  logic                           any_hit;
  logic                           full;

  // serialiser
  logic        adv;
  logic        last_byte;
  logic [7:0]  byte_d;
  logic [10:0] pay;
  logic [31:0] ram_tx_word;
  logic [31:0] ram_bus_word;

  assign take = req_valid_in && req_ready_out;
  assign any_hit = |slot_hit;
  assign full = &slot_busy;
  // codes above the bitmap width count as reserved
  assign tmf_unsupported = (req_in.tmf_func[7:5] != 3'h0) || !tmf_sup_q[req_in.tmf_func[4:0]];

  // the incoming tag probes every slot at once
  genvar g;
  generate
    for (g = 0; g < srfb_pkg::TAG_SLOTS; g++) begin : g_slot
      srfb_tag_slot u_slot (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .alloc_in (alloc_oh[g]),
        .free_in  (free_v[g]),
        .tag_in   (req_in.tag),
        .busy_out (slot_busy[g]),
        .hit_out  (slot_hit[g])
      );
    end
  endgenerate

  // first free slot gets the new tag
  always_comb begin
    alloc_oh = '0;
    for (int i = 0; i < srfb_pkg::TAG_SLOTS; i++) begin
      if (take && alloc_ok && !slot_busy[i] && (alloc_oh == '0)) begin
        alloc_oh[i] = 1'b1;
      end
    end
  end

  assign free_v = (take && release_tag) ? slot_hit : '0;

  // request decode: which format, which fields
  always_comb begin
    go          = 1'b0;
    alloc_ok    = 1'b0;
    release_tag = 1'b0;
    fmt_d       = srfb_pkg::FMT_NONE;
    status_d    = 8'h00;
    qual_d      = 16'h0000;
    sense_len_d = 16'h0000;
    reply_len_d = 11'h000;
    code_d      = srfb_pkg::RC_COMPLETE;
    extra_d     = 24'h000000;
    case (req_in.kind)
      srfb_pkg::REQ_OPEN_CMD, srfb_pkg::REQ_OPEN_TMF: begin
        if (any_hit) begin
          go     = 1'b1;
          fmt_d  = srfb_pkg::FMT_REPLY;
          code_d = srfb_pkg::RC_OVERLAP_TAG;
        end else if ((req_in.kind == srfb_pkg::REQ_OPEN_TMF) && tmf_unsupported) begin
          go     = 1'b1;
          fmt_d  = srfb_pkg::FMT_REPLY;
          code_d = srfb_pkg::RC_NOT_SUPP;
        end else if (full) begin
          // no room to track the tag: refuse rather than lose overlap checks
          go     = 1'b1;
          fmt_d  = srfb_pkg::FMT_REPLY;
          code_d = srfb_pkg::RC_FAILED;
        end else begin
          alloc_ok = 1'b1;
        end
      end
      srfb_pkg::REQ_CMD_DONE: begin
        go          = 1'b1;
        release_tag = 1'b1;
        status_d    = req_in.status;
        qual_d      = req_in.qualifier;
        if (req_in.sense_len == 16'h0000) begin
          fmt_d = srfb_pkg::FMT_NONE;
        end else begin
          fmt_d = srfb_pkg::FMT_SENSE;
          // clamp keeps the unit within the largest allowed size
          sense_len_d = (req_in.sense_len > srfb_pkg::SENSE_MAX) ?
                        srfb_pkg::SENSE_MAX : req_in.sense_len;
        end
      end
      srfb_pkg::REQ_TMF_DONE: begin
        go          = 1'b1;
        release_tag = 1'b1;
        fmt_d       = srfb_pkg::FMT_REPLY;
        code_d      = req_in.reply_code;
        extra_d     = req_in.extra_info;
      end
      srfb_pkg::REQ_XPORT_ERR: begin
        go     = 1'b1;
        fmt_d  = srfb_pkg::FMT_REPLY;
        code_d = req_in.reply_code;
      end
      default: begin
        go = 1'b0;
      end
    endcase
    if (fmt_d == srfb_pkg::FMT_REPLY) begin
      reply_len_d = srfb_pkg::REPLY_LEN;
    end
    fill_d = 2'(3'h4 - {1'b0, sense_len_d[1:0]});
  end

  // frame fields captured when a frame is started
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fmt_q       <= srfb_pkg::FMT_NONE;
      status_q    <= 8'h00;
      qual_q      <= 16'h0000;
      sense_len_q <= 16'h0000;
      reply_len_q <= 11'h000;
      code_q      <= 8'h00;
      extra_q     <= 24'h000000;
      tag_q       <= 16'h0000;
      fill_q      <= 2'h0;
      total_q     <= 11'h000;
    end else if (take && go) begin
      fmt_q       <= fmt_d;
      status_q    <= status_d;
      qual_q      <= qual_d;
      sense_len_q <= sense_len_d;
      reply_len_q <= reply_len_d;
      code_q      <= code_d;
      extra_q     <= extra_d;
      tag_q       <= req_in.tag;
      fill_q      <= fill_d;
      total_q     <= srfb_pkg::OFS_PAYLOAD + reply_len_d + sense_len_d[10:0] +
                     {9'h000, fill_d};
    end
  end

  // byte selection, most significant byte first, reserved bytes zero
  assign pay = idx_q - srfb_pkg::OFS_PAYLOAD;

  always_comb begin
    byte_d = 8'h00;
    if (idx_q == srfb_pkg::OFS_QUAL) begin
      byte_d = qual_q[15:8];
    end else if (idx_q == srfb_pkg::OFS_QUAL + 11'h001) begin
      byte_d = qual_q[7:0];
    end else if (idx_q == srfb_pkg::OFS_FMT) begin
      byte_d = {6'h00, fmt_q};
    end else if (idx_q == srfb_pkg::OFS_STATUS) begin
      byte_d = status_q;
    end else if (idx_q == srfb_pkg::OFS_SENSE_LEN + 11'h002) begin
      byte_d = sense_len_q[15:8];
    end else if (idx_q == srfb_pkg::OFS_SENSE_LEN + 11'h003) begin
      byte_d = sense_len_q[7:0];
    end else if (idx_q == srfb_pkg::OFS_REPLY_LEN + 11'h002) begin
      byte_d = {5'h00, reply_len_q[10:8]};
    end else if (idx_q == srfb_pkg::OFS_REPLY_LEN + 11'h003) begin
      byte_d = reply_len_q[7:0];
    end else if (idx_q >= srfb_pkg::OFS_PAYLOAD) begin
      if (fmt_q == srfb_pkg::FMT_REPLY) begin
        case (pay[1:0])
          2'h0:    byte_d = extra_q[23:16];
          2'h1:    byte_d = extra_q[15:8];
          2'h2:    byte_d = extra_q[7:0];
          default: byte_d = code_q;
        endcase
      end else if ((fmt_q == srfb_pkg::FMT_SENSE) && ({5'h00, pay} < sense_len_q)) begin
        case (pay[1:0])
          2'h0:    byte_d = ram_tx_word[31:24];
          2'h1:    byte_d = ram_tx_word[23:16];
          2'h2:    byte_d = ram_tx_word[15:8];
          default: byte_d = ram_tx_word[7:0];
        endcase
      end
    end
  end

  // serialiser state; a frame holds off new requests until its last byte is loaded
  assign adv = (state_q == S_EMIT) && (!tx_valid_out || tx_ready_in);
  assign last_byte = (idx_q == total_q - 11'h001);

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (take && go) begin
          state_d = S_EMIT;
        end
      end
      S_EMIT: begin
        if (adv && last_byte) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q       <= S_IDLE;
      req_ready_out <= 1'b0;
    end else begin
      state_q       <= state_d;
      req_ready_out <= (state_d == S_IDLE);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_q <= 11'h000;
    end else if (take && go) begin
      idx_q <= 11'h000;
    end else if (adv) begin
      idx_q <= idx_q + 11'h001;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_valid_out <= 1'b0;
      tx_out       <= '0;
    end else if (adv) begin
      tx_valid_out <= 1'b1;
      tx_out.data  <= byte_d;
      tx_out.last  <= last_byte;
      tx_out.fill  <= fill_q;
      tx_out.tag   <= tag_q;
    end else if (tx_ready_in) begin
      tx_valid_out <= 1'b0;
    end
  end

  srfb_sense_ram u_ram (
    .mclk_in     (mclk_in),
    .we_in       (wr_in && (addr_in == srfb_pkg::REG_SENSE_DATA)),
    .waddr_in    (sense_addr_q),
    .wdata_in    (wr_data_in),
    .raddr_a_in  (pay[9:2]),
    .rdata_a_out (ram_tx_word),
    .raddr_b_in  (sense_addr_q),
    .rdata_b_out (ram_bus_word)
  );

  // software registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmf_sup_q <= srfb_pkg::TMF_SUPPORT_RST;
    end else if (wr_in && (addr_in == srfb_pkg::REG_TMF_SUPPORT)) begin
      tmf_sup_q <= wr_data_in;
    end
  end

  // sense loads auto-increment so a whole payload is one burst of writes
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sense_addr_q <= 8'h00;
    end else if (wr_in && (addr_in == srfb_pkg::REG_SENSE_ADDR)) begin
      sense_addr_q <= wr_data_in[7:0];
    end else if (wr_in && (addr_in == srfb_pkg::REG_SENSE_DATA)) begin
      sense_addr_q <= sense_addr_q + 8'h01;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_cnt_q <= 16'h0000;
    end else if (adv && last_byte) begin
      frame_cnt_q <= frame_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 32'h00000000;
    end else if (rd_in) begin
      if (addr_in == srfb_pkg::REG_TMF_SUPPORT) begin
        rd_data_out <= tmf_sup_q;
      end else if (addr_in == srfb_pkg::REG_STATUS) begin
        rd_data_out <= {16'h0000, slot_busy, 7'h00, (state_q == S_EMIT)};
      end else if (addr_in == srfb_pkg::REG_SENSE_ADDR) begin
        rd_data_out <= {24'h000000, sense_addr_q};
      end else if (addr_in == srfb_pkg::REG_SENSE_DATA) begin
        rd_data_out <= ram_bus_word;
      end else if (addr_in == srfb_pkg::REG_FRAME_CNT) begin
        rd_data_out <= {16'h0000, frame_cnt_q};
      end else begin
        rd_data_out <= 32'h00000000;
      end
    end
  end
endmodule : srfb_builder

// File: test/srfb_builder_sva.sv
// port assertions for the response frame builder
`timescale 1ns/100ps
module srfb_builder_sva (
  // clock and reset
  input wire logic                mclk_in,
  input wire logic                rst_n_in,
  // request port
  input wire logic                req_valid_in,
  input wire srfb_pkg::srfb_req_t req_in,
  input wire logic                req_ready_out,
  // byte stream
  input wire logic                tx_valid_out,
  input wire srfb_pkg::srfb_tx_t  tx_out,
  input wire logic                tx_ready_in,
  // register port
  input wire logic [7:0]          addr_in,
  input wire logic [31:0]         wr_data_in,
  input wire logic                wr_in,
  input wire logic                rd_in,
  input wire logic [31:0]         rd_data_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic [10:0] cnt_q;
  logic [1:0]  fmt_q;
  wire         hs = tx_valid_out && tx_ready_in;
  // byte position within the frame being sent
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) cnt_q <= 11'h000;
    else if (hs) cnt_q <= tx_out.last ? 11'h000 : cnt_q + 11'h001;
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) fmt_q <= 2'h0;
    else if (hs && cnt_q == srfb_pkg::OFS_FMT) fmt_q <= tx_out.data[1:0];
  end
  sequence s_take_done;
    req_valid_in && req_ready_out && req_in.kind inside {srfb_pkg::REQ_CMD_DONE,
      srfb_pkg::REQ_TMF_DONE, srfb_pkg::REQ_XPORT_ERR};
  endsequence
  sequence s_frame_start;
    !req_ready_out ##1 tx_valid_out && tx_out.data == 8'h00;
  endsequence
  chk_frame_start: assert property (s_take_done |=> s_frame_start)
    else $error("frame did not start two edges after take");
  chk_byte_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_out))
    else $error("byte changed while stalled");
  chk_fill_steady: assert property (hs && !tx_out.last |=> tx_valid_out && $stable(tx_out.fill))
    else $error("fill count changed inside frame");
  chk_frame_align: assert property (hs && tx_out.last |-> cnt_q[1:0] == 2'h3 && cnt_q >= 11'h017)
    else $error("frame length not a dword multiple");
  chk_frame_size: assert property (hs && tx_out.last |-> cnt_q <= 11'h402)
    else $error("frame too long");
  chk_fmt_legal: assert property (tx_valid_out && cnt_q == srfb_pkg::OFS_FMT |->
    tx_out.data[7:2] == 6'h00 && tx_out.data[1:0] != srfb_pkg::FMT_RSVD)
    else $error("bad format byte");
  chk_rsvd_zero: assert property (tx_valid_out && (cnt_q < 11'h008 || cnt_q inside {[12:15]}) |->
    tx_out.data == 8'h00)
    else $error("reserved byte not zero");
  chk_reply_status: assert property (tx_valid_out && cnt_q == srfb_pkg::OFS_STATUS &&
    fmt_q == srfb_pkg::FMT_REPLY |-> tx_out.data == 8'h00)
    else $error("status not zero in reply format");
  chk_none_lens: assert property (tx_valid_out && cnt_q inside {[16:23]} &&
    fmt_q == srfb_pkg::FMT_NONE |-> tx_out.data == 8'h00)
    else $error("length not zero in no-payload format");
  chk_end_ready: assert property (hs && tx_out.last |=> !tx_valid_out ##[0:1] req_ready_out)
    else $error("not ready after last byte");
endmodule : srfb_builder_sva
bind srfb_builder srfb_builder_sva srfb_builder_sva_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
  .tx_valid_out(tx_valid_out), .tx_out(tx_out), .tx_ready_in(tx_ready_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out));

// File: test/srfb_sink_model.sv
// model of the framing side that takes response bytes
`timescale 1ns/100ps
module srfb_sink_model (
  // clock and reset
  input  wire logic               mclk_in,
  input  wire logic               rst_n_in,
  // byte stream
  input  wire logic               tx_valid_in,
  input  wire srfb_pkg::srfb_tx_t tx_in,
  output logic                    tx_ready_out,
  // stall pattern enable
  input  wire logic               stall_in
);
  logic [7:0] mem [0:1027];
  int         n_q;
  int         len_q;
  int         frames_q;
  logic [1:0] fill_q;
  logic [2:0] cyc_q;
  // holds off two cycles in eight so stalled bytes are exercised
  assign tx_ready_out = !(stall_in && cyc_q[2:1] == 2'h0);
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      n_q <= 0;
      len_q <= 0;
      frames_q <= 0;
      fill_q <= 2'h0;
      cyc_q <= 3'h0;
    end else begin
      cyc_q <= cyc_q + 3'h1;
      // fields stored; only the format byte is read, and reserved-format frames are not counted
      if (tx_valid_in && tx_ready_out) begin
        mem[n_q] <= tx_in.data;
        n_q <= tx_in.last ? 0 : n_q + 1;
        // any order accepted
        if (tx_in.last && mem[10][1:0] != srfb_pkg::FMT_RSVD) begin
          len_q <= n_q + 1;
          fill_q <= tx_in.fill;
          frames_q <= frames_q + 1;
        end
      end
    end
  end
endmodule : srfb_sink_model

// File: test/test_srfb_builder.sv
// self-checking bench for the response frame builder
`timescale 1ns/100ps
module test_srfb_builder;
  logic                mclk_in;
  logic                rst_n_in;
  logic                req_valid_in;
  srfb_pkg::srfb_req_t req_in;
  logic                req_ready_out;
  logic                tx_valid_out;
  srfb_pkg::srfb_tx_t  tx_out;
  logic                tx_ready_in;
  logic [7:0]          addr_in;
  logic [31:0]         wr_data_in;
  logic                wr_in;
  logic                rd_in;
  logic [31:0]         rd_data_out;
  logic                stall;
  logic [31:0]         rdv;
  int                  errors = 0;
  int                  tests_run = 0;
  int                  cycles = 0;
  int                  f0 = 0;

  srfb_builder srfb_builder_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
    .tx_valid_out(tx_valid_out), .tx_out(tx_out), .tx_ready_in(tx_ready_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out));
  srfb_sink_model srfb_sink_model_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .tx_valid_in(tx_valid_out), .tx_in(tx_out), .tx_ready_out(tx_ready_in), .stall_in(stall));

  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  task automatic complete_run;
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // whole run needs about 2000 cycles
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      $display("CHECK FAILED %0t timeout", $time);
      complete_run();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  function automatic logic [7:0] m(input int i);
    m = srfb_sink_model_i.mem[i];
  endfunction : m

  function automatic logic [31:0] w(input int i);
    w = {m(i), m(i + 1), m(i + 2), m(i + 3)};
  endfunction : w

  function automatic srfb_pkg::srfb_req_t mk(input srfb_pkg::srfb_kind_t kd,
      input logic [15:0] tg, input logic [15:0] sl, input logic [7:0] fn, input logic [7:0] rc);
    mk = '0;
    mk.kind = kd;
    mk.tag = tg;
    mk.status = 8'h02;
    mk.qualifier = 16'h5a3c;
    mk.sense_len = sl;
    mk.tmf_func = fn;
    mk.reply_code = rc;
  endfunction : mk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(posedge mclk_in);
    rdv = rd_data_out;
  endtask : rd

  task automatic send(input srfb_pkg::srfb_req_t r);
    int k;
    req_in <= r;
    req_valid_in <= 1'b1;
    @(posedge mclk_in);
    for (k = 0; k < 3000 && req_ready_out !== 1'b1; k++) @(posedge mclk_in);
    req_valid_in <= 1'b0;
    @(posedge mclk_in);
  endtask : send

  task automatic hdr(input logic [7:0] fmt, input logic [7:0] st, input logic [15:0] q,
                     input logic [31:0] sl, input logic [31:0] rl, input int len);
    int k;
    for (k = 0; k < 3000 && srfb_sink_model_i.frames_q == f0; k++) @(posedge mclk_in);
    f0 = srfb_sink_model_i.frames_q;
    cmp(w(0) | w(4) | w(12), 32'h0, "reserved");
    cmp({m(8), m(9)}, q, "qualifier");
    cmp(m(10), fmt, "format");
    cmp(m(11), st, "status");
    cmp(w(16), sl, "sense len");
    cmp(w(20), rl, "reply len");
    cmp(srfb_sink_model_i.len_q, len, "frame len");
  endtask : hdr

  task automatic reply(input logic [7:0] rc, input logic [23:0] ex);
    hdr(srfb_pkg::FMT_REPLY, 8'h00, 16'h0, 32'h0, 32'(srfb_pkg::REPLY_LEN), 28);
    cmp(w(24), {ex, rc}, "reply data");
  endtask : reply

  task automatic t_regs;
    rd(srfb_pkg::REG_TMF_SUPPORT);
    cmp(rdv, srfb_pkg::TMF_SUPPORT_RST, "support reset");
    wr(srfb_pkg::REG_STATUS, 32'hffffffff);
    rd(srfb_pkg::REG_STATUS);
    cmp(rdv, 32'h0, "status idle");
    rd(8'h14);
    cmp(rdv, 32'h0, "unmapped");
  endtask : t_regs

  task automatic t_nodata;
    send(mk(srfb_pkg::REQ_CMD_DONE, 16'h0001, 16'h0, 8'h00, 8'h00));
    hdr(srfb_pkg::FMT_NONE, 8'h02, 16'h5a3c, 32'h0, 32'h0, 24);
  endtask : t_nodata

  task automatic t_xport;
    send(mk(srfb_pkg::REQ_XPORT_ERR, 16'h0002, 16'h0007, 8'h00, srfb_pkg::RC_INVALID));
    reply(srfb_pkg::RC_INVALID, 24'h0);
  endtask : t_xport

  task automatic t_codes;
    logic [7:0] codes [7] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0a};
    for (int i = 0; i < 7; i++) begin
      send(mk(srfb_pkg::REQ_OPEN_TMF, 16'h0100 + 16'(i), 16'h0, 8'h00, 8'h00));
      send(mk(srfb_pkg::REQ_TMF_DONE, 16'h0100 + 16'(i), 16'h0, 8'h00, codes[i]));
      reply(codes[i], 24'h0);
    end
  endtask : t_codes

  task automatic t_overlap;
    send(mk(srfb_pkg::REQ_OPEN_CMD, 16'h0200, 16'h0, 8'h00, 8'h00));
    send(mk(srfb_pkg::REQ_OPEN_TMF, 16'h0200, 16'h0, 8'h00, 8'h00));
    reply(srfb_pkg::RC_OVERLAP_TAG, 24'h0);
    send(mk(srfb_pkg::REQ_OPEN_CMD, 16'h0200, 16'h0, 8'h00, 8'h00));
    reply(srfb_pkg::RC_OVERLAP_TAG, 24'h0);
    send(mk(srfb_pkg::REQ_CMD_DONE, 16'h0200, 16'h0, 8'h00, 8'h00));
    hdr(srfb_pkg::FMT_NONE, 8'h02, 16'h5a3c, 32'h0, 32'h0, 24);
  endtask : t_overlap

  task automatic t_unsupp;
    wr(srfb_pkg::REG_TMF_SUPPORT, 32'hfffffff7);
    send(mk(srfb_pkg::REQ_OPEN_TMF, 16'h0300, 16'h0, 8'h03, 8'h00));
    reply(srfb_pkg::RC_NOT_SUPP, 24'h0);
    send(mk(srfb_pkg::REQ_OPEN_TMF, 16'h0301, 16'h0, 8'h28, 8'h00));
    reply(srfb_pkg::RC_NOT_SUPP, 24'h0);
    wr(srfb_pkg::REG_TMF_SUPPORT, 32'hffffffff);
  endtask : t_unsupp

  task automatic t_sense(input int len);
    int el;
    int tot;
    logic [63:0] pat;
    el = len > 1000 ? 1000 : len;
    tot = 24 + (el + 3) / 4 * 4;
    pat = 64'h1122334455667788;
    wr(srfb_pkg::REG_SENSE_ADDR, 32'h0);
    wr(srfb_pkg::REG_SENSE_DATA, pat[63:32]);
    wr(srfb_pkg::REG_SENSE_DATA, pat[31:0]);
    send(mk(srfb_pkg::REQ_CMD_DONE, 16'h0400, 16'(len), 8'h00, 8'h00));
    hdr(srfb_pkg::FMT_SENSE, 8'h02, 16'h5a3c, el, 32'h0, tot);
    cmp(srfb_sink_model_i.fill_q, (4 - el % 4) % 4, "fill");
    for (int i = 0; i < 8 && i < tot - 24; i++)
      cmp(m(24 + i), i < el ? pat[63 - 8 * i -: 8] : 8'h00, "sense byte");
  endtask : t_sense

  initial begin
    rst_n_in = 1'b0;
    req_valid_in = 1'b0;
    req_in = '0;
    addr_in = 8'h00;
    wr_data_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    stall = 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    t_regs();
    t_nodata();
    stall <= 1'b1;
    t_xport();
    t_codes();
    t_overlap();
    t_unsupp();
    t_sense(5);
    t_sense(8);
    t_sense(1003);
    rd(srfb_pkg::REG_FRAME_CNT);
    cmp(rdv, 32'h11, "frames");
    complete_run();
  end
endmodule : test_srfb_builder
